/* File: src/tsc_pkg.sv */
package tsc_pkg;

	// Clock rate
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned CLK_KHZ = 250000;

	// Times in their own units
	localparam int unsigned POWERUP_TIME_MS = 300;
	localparam int unsigned RESET_TIME_MS = 30;
	localparam int unsigned START_FILT_TIME_MS = 10;
	localparam int unsigned FAST_FILT_TIME_US = 20;
	localparam int unsigned MED_FILT_TIME_MS = 2;
	localparam int unsigned SLOW_FILT_TIME_MS = 20;
	localparam int unsigned BLINK_TIME_MS = 250;
	localparam int unsigned PULSE_UNIT_MS = 10;

	// Cycle counts derived from the times
	localparam int unsigned MS_CYC = CLK_KHZ;
	localparam int unsigned POWERUP_CYC = POWERUP_TIME_MS * CLK_KHZ;
	localparam int unsigned START_FILT_CYC = START_FILT_TIME_MS * CLK_KHZ;
	localparam int unsigned FAST_FILT_CYC = FAST_FILT_TIME_US * CLK_MHZ;
	localparam int unsigned MED_FILT_CYC = MED_FILT_TIME_MS * CLK_KHZ;
	localparam int unsigned SLOW_FILT_CYC = SLOW_FILT_TIME_MS * CLK_KHZ;
	localparam int unsigned CNT_W = 27;
	localparam int unsigned MS_W = 16;

	// Time base of each range, in milliseconds
	localparam logic [MS_W-1:0] BASE_1MS = 16'h0001;
	localparam logic [MS_W-1:0] BASE_10MS = 16'h000a;
	localparam logic [MS_W-1:0] BASE_100MS = 16'h0064;
	localparam logic [MS_W-1:0] BASE_1S = 16'h03e8;
	localparam logic [MS_W-1:0] BASE_1MIN = 16'hea60;

	// Range switch codes
	localparam logic [2:0] RNG_CNT_FAST = 3'h0;
	localparam logic [2:0] RNG_CNT_SLOW = 3'h1;
	localparam logic [2:0] RNG_CNT_MED = 3'h2;
	localparam logic [2:0] RNG_T10MS = 3'h3;
	localparam logic [2:0] RNG_T100MS = 3'h4;
	localparam logic [2:0] RNG_T1MS = 3'h5;
	localparam logic [2:0] RNG_MIN_SEC = 3'h6;
	localparam logic [2:0] RNG_HR_MIN = 3'h7;

	// Values are five BCD digits, top digit 0 or 1
	localparam int unsigned DIGITS = 5;
	localparam int unsigned BCD_W = 20;
	localparam logic [BCD_W-1:0] ACC_MAX = 20'h19999;
	localparam logic [BCD_W-1:0] ACC_MAX_SEXA = 20'h19959;
	localparam logic [BCD_W-1:0] BCD_ZERO = 20'h00000;
	localparam logic [BCD_W-1:0] BCD_ONE = 20'h00001;

	// Keypad items and their reset values
	localparam int unsigned NUM_ITEMS = 5;
	localparam logic [2:0] ITEM_SP = 3'h0;
	localparam logic [2:0] ITEM_EARLY = 3'h1;
	localparam logic [2:0] ITEM_PULSE = 3'h2;
	localparam logic [2:0] ITEM_SCALE = 3'h3;
	localparam logic [2:0] ITEM_DIR = 3'h4;
	localparam logic [BCD_W-1:0] RST_SP = 20'h00100;
	localparam logic [BCD_W-1:0] RST_EARLY = 20'h00000;
	localparam logic [BCD_W-1:0] RST_PULSE = 20'h00050;
	localparam logic [BCD_W-1:0] RST_SCALE = 20'h00001;
	localparam logic [BCD_W-1:0] RST_DIR = 20'h00000;

	typedef enum logic [1:0] {
		MODE_ON_DELAY = 2'h0,
		MODE_PULSE = 2'h1,
		MODE_INTERVAL = 2'h2,
		MODE_REPEAT = 2'h3
	} out_mode_t;

	typedef enum logic [3:0] {
		ST_POWERUP = 4'h1,
		ST_IDLE = 4'h2,
		ST_RUN = 4'h4,
		ST_DONE = 4'h8
	} cycle_state_t;

	typedef enum logic [5:0] {
		MENU_RUN = 6'h01,
		MENU_SP = 6'h02,
		MENU_EARLY = 6'h04,
		MENU_PULSE = 6'h08,
		MENU_SCALE = 6'h10,
		MENU_DIR = 6'h20
	} menu_t;

	// Seven configuration switches
	typedef struct packed {
		logic count_invert;
		logic momentary;
		out_mode_t mode;
		logic [2:0] range;
	} cfg_t;

	typedef struct packed {
		logic [DIGITS-1:0] inc;
		logic [DIGITS-1:0] dec;
		logic set;
		logic confirm_entry_key;
		logic lock;
	} keys_t;

endpackage

/* File: src/signal_conditioner.sv */
`timescale 1ns/1ps
module signal_conditioner
	import tsc_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	input wire logic ce,
	// Raw level and filter length in cycles, at least one
	input wire logic raw_in,
	input wire logic [CNT_W-1:0] filt_cyc,
	// Filtered level
	output logic clean_out
);

	logic meta_q;
	logic sync_q;
	logic [CNT_W-1:0] stab_q;

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end
		else if (ce)
		begin
			meta_q <= raw_in;
			sync_q <= meta_q;
		end
	end

	// A new level must stand for the whole filter length
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			stab_q <= '0;
			clean_out <= 1'b0;
		end
		else if (ce)
		begin
			if (sync_q == clean_out)
				stab_q <= '0;
			else if (stab_q >= filt_cyc - CNT_W'(1))
			begin
				stab_q <= '0;
				clean_out <= sync_q;
			end
			else
				stab_q <= stab_q + CNT_W'(1);
		end
	end

endmodule

/* File: src/dual_setpoint_timer_counter.sv */
// How it works
// R1: On-delay mode: delayed relay closes at cycle end, holds until reset.
// R2: Pulse mode: delayed relay gives one programmed-length pulse at cycle end.
// R3: Interval mode: delayed relay is closed during the cycle, opens at end.
// R4: Repeat mode: at cycle end start the pulse, clear value, restart cycle.
// R5: Repeating continues only while start stays asserted.
// R6: As a timer the count line inhibits timing, keeping elapsed time.
// R7: Value is four and a half digits, max 19999 (19959 in the sexagesimal ranges); scale extends counts.
// R8: Three count rate settings: 7500 per second, 5000 or 500 per minute.
// R9: Five time ranges, from 0.001 s steps up to 1 minute steps.
// R10: Seven switches give count or time, range, start behaviour; read static.
// R11: Setpoint changed per digit with its own increment and decrement keys.
// R12: Keypad sets pulse length, count scale and progress direction.
// R13: Keypad lock lets the setpoint be viewed but not changed.
// R14: Activity indicator flashes while a cycle is in progress.
// R15: Unit is reset within 30 ms of start removal; with momentary start the code resets on the next start rise instead.
// R16: Unit is operational within 300 ms of power-up.
// R17: Instantaneous relay follows start, apart from delayed and early relays.
// R18: Every valid count pulse is counted, none lost.
// R19: Instantaneous relay closes with start, opens when start is removed.
// R20: Early-trip relay closes when value reaches second setpoint, opens on reset.
// R21: Start and count lines are synchronised and debounced first.
`timescale 1ns/1ps
module dual_setpoint_timer_counter
	import tsc_pkg::*;
#(
	parameter int unsigned POWERUP_CYCLES = POWERUP_CYC,
	parameter int unsigned START_FILT_CYCLES = START_FILT_CYC,
	parameter int unsigned FAST_FILT_CYCLES = FAST_FILT_CYC,
	parameter int unsigned MED_FILT_CYCLES = MED_FILT_CYC,
	parameter int unsigned SLOW_FILT_CYCLES = SLOW_FILT_CYC,
	parameter int unsigned MS_CYCLES = MS_CYC
)
(
	// Clock, reset, enable
	input wire logic mclk,
	input wire logic rstn,
	input wire logic ce,
	// Field inputs
	input wire logic start_in,
	input wire logic count_in,
	// Internal configuration switches
	input wire logic [6:0] config_sw,
	// Front keypad
	input wire keys_t keys,
	// Relays and indicators
	output logic instant_relay,
	output logic delayed_relay,
	output logic early_relay,
	output logic activity_led,
	output logic ready,
	output logic [BCD_W-1:0] display,
	output menu_t menu_view
);

	cfg_t cfg_q;
	cycle_state_t state_q;
	menu_t menu_q;
	logic [BCD_W-1:0] items_q [NUM_ITEMS];
	logic [BCD_W-1:0] acc_q;
	logic [BCD_W-1:0] scl_q;
	logic [BCD_W-1:0] pulse_cnt_q;
	logic pulse_q;
	logic [CNT_W-1:0] pwr_cnt_q;
	logic [CNT_W-1:0] tmr_cyc_q;
	logic [MS_W-1:0] tmr_ms_q;
	logic [CNT_W-1:0] free_cyc_q;
	logic [MS_W-1:0] pulse_ms_q;
	logic [MS_W-1:0] blink_ms_q;
	logic blink_q;
	logic start_prev_q;
	logic count_prev_q;
	logic [DIGITS*2+1:0] keys_prev_q;

	logic [1:0] raw_lines;
	logic [1:0] clean_lines;
	logic [CNT_W-1:0] filt_len [2];
	logic start_c;
	logic count_lvl;
	logic start_rise;
	logic start_fall;
	logic is_timer;
	logic sexa;
	logic [MS_W-1:0] base_ms;
	logic free_ms_tick;
	logic time_tick;
	logic cnt_tick;
	logic advance;
	logic hit;
	logic begin_cycle;
	logic cycle_reset;
	logic [BCD_W-1:0] acc_next;
	logic [BCD_W-1:0] scl_next;
	logic [BCD_W-1:0] scale_eff;
	logic [BCD_W-1:0] pulse_next;
	logic [BCD_W-1:0] pulse_len;
	logic [BCD_W-1:0] max_val;
	logic [DIGITS-1:0] inc_p;
	logic [DIGITS-1:0] dec_p;
	logic set_p;
	logic enter_p;
	logic [2:0] cur_item;
	logic [BCD_W-1:0] edit_val;

	// BCD increment; in sexagesimal ranges the tens digit wraps at 5
	function automatic logic [BCD_W-1:0] bcd_inc(input logic [BCD_W-1:0] v,
		input logic sx);
		logic [BCD_W-1:0] r;
		logic carry;
		logic [3:0] lim;
		r = v;
		carry = 1'b1;
		for (int i = 0; i < DIGITS; i++)
		begin
			lim = (sx && i == 1) ? 4'h5 : 4'h9;
			if (carry)
			begin
				if (r[4*i +: 4] == lim)
					r[4*i +: 4] = 4'h0;
				else
				begin
					r[4*i +: 4] = r[4*i +: 4] + 4'h1;
					carry = 1'b0;
				end
			end
		end
		return r;
	endfunction

	// Remaining value for the count-down view
	function automatic logic [BCD_W-1:0] bcd_sub(input logic [BCD_W-1:0] a,
		input logic [BCD_W-1:0] b, input logic sx);
		logic [BCD_W-1:0] r;
		logic borrow;
		logic [4:0] t;
		r = BCD_ZERO;
		borrow = 1'b0;
		for (int i = 0; i < DIGITS; i++)
		begin
			t = {1'b0, a[4*i +: 4]} - {1'b0, b[4*i +: 4]} - {4'h0, borrow};
			borrow = t[4];
			if (t[4])
				t = t + ((sx && i == 1) ? 5'h06 : 5'h0a);
			r[4*i +: 4] = t[3:0];
		end
		if (b > a)
			r = BCD_ZERO;
		return r;
	endfunction

	assign raw_lines = {count_in, start_in};
	assign filt_len[0] = CNT_W'(START_FILT_CYCLES);
	always_comb
	begin
		case (cfg_q.range)
			RNG_CNT_SLOW: filt_len[1] = CNT_W'(SLOW_FILT_CYCLES); // [R8]
			RNG_CNT_MED: filt_len[1] = CNT_W'(MED_FILT_CYCLES); // [R8]
			default: filt_len[1] = CNT_W'(FAST_FILT_CYCLES); // [R8]
		endcase
	end

	// Start filter is well below the reset time budget
	for (genvar g = 0; g < 2; g++)
	begin : g_cond
		signal_conditioner u_cond (
			.mclk(mclk),
			.rstn(rstn),
			.ce(ce),
			.raw_in(raw_lines[g]),
			.filt_cyc(filt_len[g]),
			.clean_out(clean_lines[g])
		); // [R21]
	end

	assign start_c = clean_lines[0];
	assign count_lvl = clean_lines[1] ^ cfg_q.count_invert;
	assign start_rise = start_c & ~start_prev_q;
	assign start_fall = ~start_c & start_prev_q;
	assign is_timer = cfg_q.range >= RNG_T10MS;
	assign sexa = cfg_q.range == RNG_MIN_SEC || cfg_q.range == RNG_HR_MIN;
	assign max_val = sexa ? ACC_MAX_SEXA : ACC_MAX;
	assign inc_p = keys.inc & ~keys_prev_q[DIGITS*2+1:DIGITS+2];
	assign dec_p = keys.dec & ~keys_prev_q[DIGITS+1:2];
	assign set_p = keys.set & ~keys_prev_q[1];
	assign enter_p = keys.confirm_entry_key & ~keys_prev_q[0];

	always_comb
	begin
		case (cfg_q.range)
			RNG_T10MS: base_ms = BASE_10MS; // [R9]
			RNG_T100MS: base_ms = BASE_100MS;
			RNG_MIN_SEC: base_ms = BASE_1S;
			RNG_HR_MIN: base_ms = BASE_1MIN; // [R9]
			default: base_ms = BASE_1MS; // [R9]
		endcase
	end

	// Cycle start, restart and reset events
	assign cycle_reset = (state_q == ST_RUN || state_q == ST_DONE) &&
		(cfg_q.momentary ? start_rise : start_fall); // [R15]
	assign begin_cycle = (state_q == ST_IDLE &&
		(cfg_q.momentary ? start_rise : start_c)) ||
		(state_q == ST_DONE && cfg_q.momentary && start_rise);

	// Timer prescaler holds while inhibited, so elapsed time is kept
	assign time_tick = is_timer && state_q == ST_RUN && !count_lvl &&
		tmr_cyc_q == CNT_W'(MS_CYCLES - 1) && tmr_ms_q >= base_ms - 16'h0001;
	assign scale_eff = items_q[ITEM_SCALE] == BCD_ZERO ? BCD_ONE :
		items_q[ITEM_SCALE];
	assign scl_next = bcd_inc(scl_q, 1'b0);
	assign cnt_tick = !is_timer && state_q == ST_RUN &&
		count_lvl && !count_prev_q && scl_next >= scale_eff; // [R18]
	assign advance = (time_tick || cnt_tick) && acc_q != max_val; // [R7]
	assign acc_next = bcd_inc(acc_q, sexa);
	assign hit = advance && acc_next == items_q[ITEM_SP];

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			start_prev_q <= 1'b0;
			count_prev_q <= 1'b0;
			keys_prev_q <= '0;
		end
		else if (ce)
		begin
			start_prev_q <= start_c;
			count_prev_q <= count_lvl;
			keys_prev_q <= {keys.inc, keys.dec, keys.set,
				keys.confirm_entry_key};
		end
	end

	// Power-up hold-off
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			pwr_cnt_q <= '0;
			ready <= 1'b0;
		end
		else if (ce && !ready)
		begin
			if (pwr_cnt_q >= CNT_W'(POWERUP_CYCLES - 1))
				ready <= 1'b1; // [R16]
			else
				pwr_cnt_q <= pwr_cnt_q + CNT_W'(1);
		end
	end

	// Switches are static: sampled only while no cycle is active
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			cfg_q <= '0;
		else if (ce && (state_q == ST_POWERUP || state_q == ST_IDLE))
			cfg_q <= cfg_t'(config_sw); // [R10]
	end

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			state_q <= ST_POWERUP;
		else if (ce)
		begin
			case (state_q)
				ST_POWERUP:
					if (ready)
						state_q <= ST_IDLE;
				ST_IDLE:
					if (begin_cycle)
						state_q <= ST_RUN;
				ST_RUN:
					if (cycle_reset || (!cfg_q.momentary && !start_c))
						state_q <= ST_IDLE; // [R15]
					else if (hit && !(cfg_q.mode == MODE_REPEAT && start_c))
						state_q <= ST_DONE; // [R5]
				ST_DONE:
					if (begin_cycle)
						state_q <= ST_RUN;
					else if (cycle_reset)
						state_q <= ST_IDLE;
				default:
					state_q <= ST_POWERUP;
			endcase
		end
	end

	// Accumulated value and count prescaler
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			acc_q <= BCD_ZERO;
			scl_q <= BCD_ZERO;
		end
		else if (ce)
		begin
			if (begin_cycle || cycle_reset)
			begin
				acc_q <= BCD_ZERO;
				scl_q <= BCD_ZERO;
			end
			else if (hit && cfg_q.mode == MODE_REPEAT && start_c)
				acc_q <= BCD_ZERO; // [R4]
			else if (advance)
				acc_q <= acc_next;
			if (!is_timer && state_q == ST_RUN && count_lvl && !count_prev_q)
				scl_q <= cnt_tick ? BCD_ZERO : scl_next; // [R18]
		end
	end

	// Timing prescaler, frozen by the inhibit line
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			tmr_cyc_q <= '0;
			tmr_ms_q <= '0;
		end
		else if (ce)
		begin
			if (begin_cycle || cycle_reset)
			begin
				tmr_cyc_q <= '0;
				tmr_ms_q <= '0;
			end
			else if (is_timer && state_q == ST_RUN && !count_lvl) // [R6]
			begin
				if (tmr_cyc_q == CNT_W'(MS_CYCLES - 1))
				begin
					tmr_cyc_q <= '0;
					tmr_ms_q <= time_tick ? '0 : tmr_ms_q + 16'h0001;
				end
				else
					tmr_cyc_q <= tmr_cyc_q + CNT_W'(1);
			end
		end
	end

	// Free millisecond base for the output pulse and the flasher
	assign free_ms_tick = free_cyc_q == CNT_W'(MS_CYCLES - 1);
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			free_cyc_q <= '0;
			blink_ms_q <= '0;
			blink_q <= 1'b0;
		end
		else if (ce)
		begin
			free_cyc_q <= free_ms_tick ? '0 : free_cyc_q + CNT_W'(1);
			if (free_ms_tick)
			begin
				if (blink_ms_q == MS_W'(BLINK_TIME_MS - 1))
				begin
					blink_ms_q <= '0;
					blink_q <= ~blink_q;
				end
				else
					blink_ms_q <= blink_ms_q + 16'h0001;
			end
		end
	end

	// Output pulse, at least one pulse unit long
	assign pulse_next = bcd_inc(pulse_cnt_q, 1'b0);
	assign pulse_len = items_q[ITEM_PULSE] == BCD_ZERO ? BCD_ONE :
		items_q[ITEM_PULSE];
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			pulse_q <= 1'b0;
			pulse_cnt_q <= BCD_ZERO;
			pulse_ms_q <= '0;
		end
		else if (ce)
		begin
			if (cycle_reset || begin_cycle)
				pulse_q <= 1'b0;
			else if (hit && (cfg_q.mode == MODE_PULSE ||
				cfg_q.mode == MODE_REPEAT))
			begin
				pulse_q <= 1'b1; // [R2] [R4]
				pulse_cnt_q <= BCD_ZERO;
				pulse_ms_q <= '0;
			end
			else if (pulse_q && free_ms_tick)
			begin
				if (pulse_ms_q == MS_W'(PULSE_UNIT_MS - 1))
				begin
					pulse_ms_q <= '0;
					pulse_cnt_q <= pulse_next;
					if (pulse_next >= pulse_len)
						pulse_q <= 1'b0; // [R2]
				end
				else
					pulse_ms_q <= pulse_ms_q + 16'h0001;
			end
		end
	end

	// Relays and indicator
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			instant_relay <= 1'b0;
			delayed_relay <= 1'b0;
			early_relay <= 1'b0;
			activity_led <= 1'b0;
		end
		else if (ce)
		begin
			instant_relay <= ready && start_c; // [R17] [R19]
			case (cfg_q.mode)
				MODE_ON_DELAY: delayed_relay <= state_q == ST_DONE; // [R1]
				MODE_INTERVAL: delayed_relay <= state_q == ST_RUN; // [R3]
				default: delayed_relay <= pulse_q; // [R2] [R4]
			endcase
			if (cycle_reset || begin_cycle ||
				(hit && cfg_q.mode == MODE_REPEAT && start_c))
				early_relay <= 1'b0; // [R20]
			else if (state_q == ST_RUN && items_q[ITEM_EARLY] != BCD_ZERO &&
				acc_q >= items_q[ITEM_EARLY])
				early_relay <= 1'b1; // [R20]
			activity_led <= state_q == ST_RUN && blink_q; // [R14]
		end
	end

	// Keypad menu; locked unit only toggles into the setpoint view
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			menu_q <= MENU_RUN;
		else if (ce)
		begin
			if (enter_p)
				menu_q <= MENU_RUN;
			else if (set_p && keys.lock)
				menu_q <= menu_q == MENU_RUN ? MENU_SP : MENU_RUN; // [R13]
			else if (set_p)
			begin
				case (menu_q)
					MENU_RUN: menu_q <= MENU_SP;
					MENU_SP: menu_q <= MENU_EARLY;
					MENU_EARLY: menu_q <= MENU_PULSE;
					MENU_PULSE: menu_q <= MENU_SCALE;
					MENU_SCALE: menu_q <= MENU_DIR;
					default: menu_q <= MENU_RUN;
				endcase
			end
		end
	end
	assign menu_view = menu_q;

	always_comb
	begin
		case (menu_q)
			MENU_EARLY: cur_item = ITEM_EARLY;
			MENU_PULSE: cur_item = ITEM_PULSE;
			MENU_SCALE: cur_item = ITEM_SCALE;
			MENU_DIR: cur_item = ITEM_DIR;
			default: cur_item = ITEM_SP;
		endcase
	end

	// Per-digit step with wrap; top digit is a half digit
	for (genvar d = 0; d < DIGITS; d++)
	begin : g_digit
		logic [3:0] lim;
		logic [3:0] cur;
		assign cur = items_q[cur_item][4*d +: 4];
		assign lim = (d == DIGITS - 1 || cur_item == ITEM_DIR) ? 4'h1 :
			(d == 1 && sexa && cur_item <= ITEM_EARLY) ? 4'h5 : 4'h9; // [R7]
		always_comb
		begin
			if (inc_p[d])
				edit_val[4*d +: 4] = cur >= lim ? 4'h0 : cur + 4'h1; // [R11]
			else if (dec_p[d])
				edit_val[4*d +: 4] = cur == 4'h0 ? lim : cur - 4'h1; // [R11]
			else
				edit_val[4*d +: 4] = cur;
		end
	end

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			items_q[ITEM_SP] <= RST_SP;
			items_q[ITEM_EARLY] <= RST_EARLY;
			items_q[ITEM_PULSE] <= RST_PULSE;
			items_q[ITEM_SCALE] <= RST_SCALE;
			items_q[ITEM_DIR] <= RST_DIR;
		end
		else if (ce && menu_q != MENU_RUN && !keys.lock &&
			(inc_p != '0 || dec_p != '0))
			items_q[cur_item] <= edit_val; // [R12] [R13]
	end

	// Display: value in run view, else the item being edited
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			display <= BCD_ZERO;
		else if (ce)
		begin
			if (menu_q != MENU_RUN)
				display <= items_q[cur_item];
			else if (items_q[ITEM_DIR][0])
				display <= acc_q; // [R12]
			else
				display <= bcd_sub(items_q[ITEM_SP], acc_q, sexa); // [R12]
		end
	end

endmodule

/* File: tb/tsc_monitor.sv */
`timescale 1ns/1ps
module tsc_monitor
	import tsc_pkg::*;
#(
	parameter int unsigned POWERUP_CYCLES = 20,
	parameter int unsigned START_FILT_CYCLES = 4,
	parameter int unsigned MS_CYCLES = 10
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	input wire logic ce,
	// Inputs
	input wire logic start_in,
	input wire logic [6:0] config_sw,
	// Outputs
	input wire logic instant_relay,
	input wire logic delayed_relay,
	input wire logic early_relay,
	input wire logic activity_led,
	input wire logic ready,
	input wire logic [BCD_W-1:0] display
);
	// Pulse bound assumes the reset pulse length, plus one tick of jitter
	localparam int unsigned PW_MAX = 501 * MS_CYCLES + 2;
	localparam int unsigned LAG = START_FILT_CYCLES + 6;
	int unsigned up_q, lo_q, hi_q, pw_q;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	always_ff @(posedge mclk or negedge rstn)
		if (!rstn)
		begin
			up_q <= 0;
			lo_q <= 0;
			hi_q <= 0;
			pw_q <= 0;
		end
		else if (ce)
		begin
			up_q <= up_q + (up_q < 32'hfffff);
			lo_q <= start_in ? 0 : lo_q + (lo_q < 32'hfffff);
			hi_q <= !start_in ? 0 : hi_q + (hi_q < 32'hfffff);
			pw_q <= delayed_relay ? pw_q + (pw_q < 32'hfffff) : 0;
		end
	property p_ready_hold;
		ready |=> ready;
	endproperty
	a_ready_hold: assert property (p_ready_hold) else $error("ready fell");
	property p_ready_late;
		up_q > POWERUP_CYCLES + 3 |-> ready;
	endproperty
	a_ready_late: assert property (p_ready_late) else $error("ready late");
	property p_ready_early;
		up_q + 1 < POWERUP_CYCLES |-> !ready;
	endproperty
	a_ready_early: assert property (p_ready_early) else $error("ready early");
	property p_quiet;
		!ready |-> !(instant_relay || delayed_relay || early_relay);
	endproperty
	a_quiet: assert property (p_quiet) else $error("relay before ready");
	property p_removed;
		!config_sw[5] && lo_q > LAG |-> !(instant_relay || delayed_relay
			|| early_relay || activity_led);
	endproperty
	a_removed: assert property (p_removed) else $error("no reset");
	property p_inst_start;
		$rose(instant_relay) |-> hi_q >= START_FILT_CYCLES;
	endproperty
	a_inst_start: assert property (p_inst_start) else $error("instant");
	property p_interval;
		!config_sw[5] && config_sw[4:3] == MODE_INTERVAL && delayed_relay
			|-> hi_q > 0 || lo_q < LAG;
	endproperty
	a_interval: assert property (p_interval) else $error("interval");
	property p_pulse_len;
		config_sw[3] |-> pw_q <= PW_MAX;
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("pulse long");
	property p_disp_max;
		display <= ACC_MAX;
	endproperty
	a_disp_max: assert property (p_disp_max) else $error("display max");
	property p_bcd;
		display[3:0] < 4'ha && display[7:4] < 4'ha && display[11:8] < 4'ha
			&& display[15:12] < 4'ha;
	endproperty
	a_bcd: assert property (p_bcd) else $error("display digit");
	property p_on_hold;
		!config_sw[5] && config_sw[4:3] == MODE_ON_DELAY && $fell(delayed_relay)
			|-> lo_q >= START_FILT_CYCLES;
	endproperty
	a_on_hold: assert property (p_on_hold) else $error("on-delay drop");
	c_done: cover property ($rose(delayed_relay));
	c_pulse: cover property (config_sw[4:3] == MODE_PULSE && $fell(delayed_relay));
	c_start: cover property ($rose(instant_relay));
endmodule
bind dual_setpoint_timer_counter tsc_monitor #(
	.POWERUP_CYCLES(POWERUP_CYCLES),
	.START_FILT_CYCLES(START_FILT_CYCLES),
	.MS_CYCLES(MS_CYCLES)
) mon (.mclk(mclk), .rstn(rstn), .ce(ce), .start_in(start_in),
	.config_sw(config_sw), .instant_relay(instant_relay),
	.delayed_relay(delayed_relay), .early_relay(early_relay),
	.activity_led(activity_led), .ready(ready), .display(display));

/* File: tb/field_model.sv */
`timescale 1ns/1ps
module field_model
(
	// Clock
	input wire logic mclk,
	// Requests
	input wire logic go,
	input wire logic hold,
	input wire logic [15:0] n_pulses,
	// Line into the unit and busy flag
	output logic count_in,
	output logic busy
);
	int seed = 85;
	initial
	begin
		count_in = 0;
		busy = 0;
		forever
		begin
			@(posedge mclk);
			if (!go)
				count_in <= hold;
			else
			begin
				busy <= 1;
				// Widths stay above the slowest filter so no pulse is lost
				repeat (n_pulses)
				begin
					count_in <= 1;
					repeat (8 + ($random(seed) & 3)) @(posedge mclk);
					count_in <= 0;
					repeat (8 + ($random(seed) & 3)) @(posedge mclk);
				end
				busy <= 0;
			end
		end
	end
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
	import tsc_pkg::*;
	typedef struct {int sel; logic [19:0] exp; string nm;} note_t;
	logic mclk = 0;
	logic rstn = 0;
	logic ce = 1;
	logic start_in = 0;
	logic [6:0] config_sw = 7'h05;
	keys_t keys = '0;
	logic m_go = 0;
	logic m_hold = 0;
	logic [15:0] m_num = 16'h0000;
	logic instant_relay, delayed_relay, early_relay, activity_led, ready;
	logic count_in, m_busy;
	logic [BCD_W-1:0] display;
	menu_t menu_view;
	int mismatches = 0;
	int cmp_count = 0;
	int meas = 0;
	note_t notes[$];
	always #2 mclk = ~mclk;
	dual_setpoint_timer_counter #(.POWERUP_CYCLES(20), .START_FILT_CYCLES(4),
		.FAST_FILT_CYCLES(2), .MED_FILT_CYCLES(3), .SLOW_FILT_CYCLES(5),
		.MS_CYCLES(10)) dut (.mclk(mclk), .rstn(rstn), .ce(ce),
		.start_in(start_in), .count_in(count_in), .config_sw(config_sw),
		.keys(keys), .instant_relay(instant_relay),
		.delayed_relay(delayed_relay), .early_relay(early_relay),
		.activity_led(activity_led), .ready(ready), .display(display),
		.menu_view(menu_view));
	field_model far (.mclk(mclk), .go(m_go), .hold(m_hold),
		.n_pulses(m_num), .count_in(count_in), .busy(m_busy));
	function automatic logic [19:0] obs(int s);
		case (s)
			0: return 20'(delayed_relay);
			1: return 20'(instant_relay);
			2: return 20'(early_relay);
			3: return 20'(ready);
			4: return display;
			5: return 20'(menu_view);
			6: return 20'(m_busy);
			default: return 20'(meas);
		endcase
	endfunction
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(string nm, logic [19:0] seen, logic [19:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	always @(negedge mclk)
		while (notes.size() > 0)
		begin
			note_t n;
			n = notes.pop_front();
			check(n.nm, obs(n.sel), n.exp);
		end
	task automatic note(int s, logic [19:0] e, string nm);
		notes.push_back('{s, e, nm});
	endtask
	task automatic cyc(int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic wait_out(int s, logic [19:0] v, int lim);
		for (int i = 0; i < lim && obs(s) !== v; i++)
			@(negedge mclk);
	endtask
	task automatic press(logic [12:0] k, logic lk);
		@(posedge mclk);
		keys <= keys_t'(k | 13'(lk));
		repeat (2) @(posedge mclk);
		keys <= keys_t'(13'(lk));
		repeat (3) @(posedge mclk);
	endtask
	task automatic pulses(int n);
		@(posedge mclk);
		m_num <= 16'(n);
		m_go <= 1;
		@(posedge mclk);
		m_go <= 0;
		// Busy is only seen after the model has taken the request
		wait_out(6, 1, 4);
		wait_out(6, 0, 3000);
		cyc(12);
	endtask
	task automatic run_mode(logic [1:0] md, bit inh);
		@(posedge mclk) config_sw <= {2'b00, md, RNG_T1MS};
		@(posedge mclk) start_in <= 1;
		wait_out(1, 1, 30);
		cyc(3);
		note(1, 1, "instant");
		note(0, 20'(md == MODE_INTERVAL), "delayed run");
		note(2, 0, "early");
		if (inh)
		begin
			cyc(300);
			@(posedge mclk) m_hold <= 1;
			cyc(500);
			@(posedge mclk) m_hold <= 0;
			cyc(400);
			note(0, 0, "inhibited");
		end
		wait_out(0, 20'(md != MODE_INTERVAL), 1300);
		note(0, 20'(md != MODE_INTERVAL), "cycle end");
		note(2, 20'(md != MODE_REPEAT), "early end");
		meas = 0;
		if (md == MODE_PULSE)
			while (delayed_relay === 1 && meas < 6000)
			begin
				@(negedge mclk);
				meas++;
			end
		else
			cyc(300);
		case (md)
			MODE_PULSE: meas = (meas > 4989 && meas < 5013);
			MODE_REPEAT: meas = (display > 20'h00060 && display < 20'h00080);
			default: meas = (obs(0) === 20'(md == MODE_ON_DELAY));
		endcase
		note(7, 1, "mode result");
		@(posedge mclk) start_in <= 0;
		cyc(12);
		note(1, 0, "instant off");
		note(0, 0, "delayed off");
		$display("done mode %0d", md);
	endtask
	task automatic run_count(logic [2:0] rg);
		@(posedge mclk) config_sw <= {rg == 3'h2, 3'h0, rg};
		@(posedge mclk) start_in <= 1;
		wait_out(1, 1, 30);
		pulses(99);
		note(4, 20'h00001, "remaining");
		note(2, 1, "early trip");
		note(0, 0, "short");
		pulses(1);
		note(0, 1, "count done");
		@(posedge mclk) start_in <= 0;
		cyc(12);
		$display("done range %0d", rg);
	endtask
	initial
	begin
		repeat (5) @(posedge mclk);
		rstn <= 1;
		cyc(3);
		note(3, 0, "not ready");
		wait_out(3, 1, 40);
		note(3, 1, "ready");
		press(13'h0004, 0);
		note(5, MENU_SP, "sp view");
		press(13'h0100, 0);
		note(4, 20'h00101, "inc");
		press(13'h0200, 1);
		note(4, 20'h00101, "locked");
		press(13'h0008, 0);
		note(4, 20'h00100, "dec");
		press(13'h0004, 0);
		note(5, MENU_EARLY, "early view");
		press(13'h0010, 0);
		note(4, 20'h00090, "early set");
		// Keys pressed while frozen must leave no trace
		@(posedge mclk) ce <= 0;
		press(13'h0100, 0);
		@(posedge mclk) ce <= 1;
		cyc(3);
		note(4, 20'h00090, "frozen");
		press(13'h0002, 0);
		note(5, MENU_RUN, "run view");
		$display("done keypad");
		run_mode(MODE_ON_DELAY, 1);
		for (int m = 0; m < 4; m++)
			run_mode(2'(m), 0);
		for (int r = 0; r < 3; r++)
			run_count(3'(r));
		end_of_test();
	end
	initial
	begin
		repeat (60000) @(posedge mclk);
		mismatches++;
		end_of_test();
	end
endmodule
